// [pkg/ddrx_pkg.sv]
// Constants and types shared by the read/write strobe transfer block.
// Assumes a 40 MHz ref_clk and a 200 ns memory strobe period.
package ddrx_pkg;
    localparam int DQ_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int BURST_BEATS = 4;
    localparam int REF_PERIOD_PS = 25000;
    localparam int LINK_PERIOD_NS = 200;
    // Cycles per strobe period, and its quarter and half
    localparam int LINK_DIV_CYC = (LINK_PERIOD_NS * 1000) / REF_PERIOD_PS;
    localparam int QUARTER_CYC = LINK_DIV_CYC / 4;
    localparam int HALF_CYC = LINK_DIV_CYC / 2;
    localparam logic [3:0] DIV_RESET = 4'h0;
    localparam logic [2:0] BEAT_RESET = 3'h0;

    typedef enum {
        DDRX_IDLE,
        DDRX_PREAMBLE,
        DDRX_FIRST_RISE,
        DDRX_BURST,
        DDRX_WRITE
    } ddrx_state_t;

    typedef struct packed {
        logic [DQ_W-1:0] data;
        logic last;
    } ddrx_beat_t;
endpackage

// [core/ddrx_read_xfer.sv]
// Strobe transfer block: read capture with polarity selection, FIFO,
// and write strobe shifted by a quarter period.
// Assumes strobe and data pins arrive asynchronously to ref_clk.
`timescale 1ns/1ps

// Plain synchronous FIFO, valid/ready on both sides
module ddrx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // Pointer and fill level update
    always_comb begin
        push = inValid && inReady;
        pop = outValid && outReady;
        next_wrPtr = push ? AW'(wrPtr + 1'b1) : wrPtr;
        next_rdPtr = pop ? AW'(rdPtr + 1'b1) : rdPtr;
        next_count = (AW+1)'(count + push - pop);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
endmodule

module ddrx_read_xfer import ddrx_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic readStart,
    input wire logic writeStart,
    input wire logic strobeIn,
    output logic strobeOut,
    output logic strobeOe_n,
    input wire logic [DQ_W-1:0] dqIn,
    output logic [DQ_W-1:0] dqOut,
    output logic dqOe_n,
    output logic [DQ_W-1:0] writeQuarterShift,
    input wire logic [DQ_W-1:0] wrData,
    output logic wrTake,
    output logic rdValid,
    input wire logic rdReady,
    output ddrx_beat_t rdBeat,
    output logic busy,
    output logic polarity,
    output logic overrun
);
    ddrx_state_t state, next_state;
    logic [2:0] strobeSync;
    logic [DQ_W-1:0] dqS1, dqS2, dqS3;
    logic strobeLvl, next_strobeLvl;
    logic sysPhase, next_polarity;
    logic [3:0] divCnt, next_divCnt;
    logic [2:0] beatCnt, next_beatCnt;
    ddrx_beat_t stage, next_stage;
    logic stageFull, next_stageFull, next_overrun;
    logic [DQ_W-1:0] next_dqOut;
    logic next_strobeOut, next_strobeOe_n, next_dqOe_n;
    logic agree, strobeRise, strobeEdge, xferNow, fifoInReady;

    // Three-stage pin synchronisers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobeSync <= 3'h7; // Idle level of the pulled-up pin
            dqS1 <= '0;
            dqS2 <= '0;
            dqS3 <= '0;
        end else begin
            strobeSync <= {strobeSync[1:0], strobeIn};
            dqS1 <= dqIn;
            dqS2 <= dqS1;
            dqS3 <= dqS2;
        end
    end

    // Filtered strobe level changes only when stages two and three agree
    always_comb begin
        agree = (strobeSync[1] == strobeSync[2]);
        next_strobeLvl = agree ? strobeSync[2] : strobeLvl;
        strobeRise = agree && strobeSync[2] && !strobeLvl;
        strobeEdge = agree && (strobeSync[2] != strobeLvl);
        xferNow = stageFull && (sysPhase == polarity) && fifoInReady;
    end

    // Main sequencing: preamble search, read burst, write burst
    always_comb begin
        next_state = state;
        next_polarity = polarity;
        next_beatCnt = beatCnt;
        next_divCnt = DIV_RESET;
        next_stage = stage;
        next_stageFull = stageFull && !xferNow;
        next_overrun = overrun;
        next_dqOut = dqOut;
        next_strobeOut = 1'b0;
        next_strobeOe_n = 1'b1;
        next_dqOe_n = 1'b1;
        wrTake = 1'b0;
        case (state)
            DDRX_IDLE: begin
                next_beatCnt = BEAT_RESET;
                if (writeStart) begin
                    next_state = DDRX_WRITE;
                end else if (readStart) begin
                    next_state = DDRX_PREAMBLE;
                    next_overrun = 1'b0;
                end
            end
            DDRX_PREAMBLE: begin
                // Floating strobe reads high until memory drives it low
                if (agree && !strobeSync[2]) begin
                    next_state = DDRX_FIRST_RISE;
                end
            end
            DDRX_FIRST_RISE: begin
                // First rise carries beat zero and fixes the polarity
                if (strobeRise) begin
                    if (stageFull && !xferNow) begin
                        next_overrun = 1'b1;
                    end
                    next_polarity = sysPhase;
                    next_stage.data = dqS3;
                    next_stage.last = 1'b0;
                    next_stageFull = 1'b1;
                    next_beatCnt = 3'(beatCnt + 1'b1);
                    next_state = DDRX_BURST;
                end
            end
            DDRX_BURST: begin
                // Polarity frozen for the burst
                if (strobeEdge) begin
                    if (stageFull && !xferNow) begin
                        next_overrun = 1'b1;
                    end
                    next_stage.data = dqS3;
                    next_stage.last = (beatCnt == 3'(BURST_BEATS - 1));
                    next_stageFull = 1'b1;
                    next_beatCnt = 3'(beatCnt + 1'b1);
                    if (beatCnt == 3'(BURST_BEATS - 1)) begin
                        next_state = DDRX_IDLE;
                    end
                end
            end
            DDRX_WRITE: begin
                next_strobeOe_n = 1'b0;
                next_dqOe_n = 1'b0;
                next_divCnt = 4'(divCnt + 1'b1);
                if (divCnt == 4'(LINK_DIV_CYC - 1)) begin
                    next_divCnt = DIV_RESET;
                end
                // Strobe edge a quarter period after each data launch
                next_strobeOut = (divCnt >= 4'(QUARTER_CYC))
                    && (divCnt < 4'(QUARTER_CYC + HALF_CYC));
                if (divCnt == DIV_RESET || divCnt == 4'(HALF_CYC)) begin
                    if (beatCnt == 3'(BURST_BEATS)) begin
                        next_state = DDRX_IDLE;
                        next_strobeOe_n = 1'b1;
                        next_dqOe_n = 1'b1;
                        next_strobeOut = 1'b0;
                    end else begin
                        wrTake = 1'b1;
                        next_dqOut = wrData;
                        next_beatCnt = 3'(beatCnt + 1'b1);
                    end
                end
            end
            default: next_state = DDRX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= DDRX_IDLE;
            strobeLvl <= 1'b1;
            sysPhase <= 1'b0;
            polarity <= 1'b0;
            beatCnt <= BEAT_RESET;
            divCnt <= DIV_RESET;
            stage <= '0;
            stageFull <= 1'b0;
            overrun <= 1'b0;
            dqOut <= '0;
            strobeOut <= 1'b0;
            strobeOe_n <= 1'b1;
            dqOe_n <= 1'b1;
        end else begin
            state <= next_state;
            strobeLvl <= next_strobeLvl;
            sysPhase <= !sysPhase;
            polarity <= next_polarity;
            beatCnt <= next_beatCnt;
            divCnt <= next_divCnt;
            stage <= next_stage;
            stageFull <= next_stageFull;
            overrun <= next_overrun;
            dqOut <= next_dqOut;
            strobeOut <= next_strobeOut;
            strobeOe_n <= next_strobeOe_n;
            dqOe_n <= next_dqOe_n;
        end
    end

    // Shifted write strobe fanned out to every data lane
    genvar lane;
    generate
        for (lane = 0; lane < DQ_W; lane++) begin : g_lane
            assign writeQuarterShift[lane] = strobeOut;
        end
    endgenerate

    assign busy = (state != DDRX_IDLE);

    // Read beats queue for the user side
    ddrx_fifo #(
        .WIDTH($bits(ddrx_beat_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inValid(xferNow),
        .inReady(fifoInReady),
        .inData(stage),
        .outValid(rdValid),
        .outReady(rdReady),
        .outData(rdBeat)
    );
endmodule

// [bench/ddrx_read_xfer_monitor.sv]
// Checker for the strobe transfer block, bound to its top module.
// Assumes one clock domain, ref_clk, with async active-low rst_n.
`timescale 1ns/1ps
module ddrx_read_xfer_monitor import ddrx_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic readStart,
    input wire logic writeStart,
    input wire logic strobeOut,
    input wire logic strobeOe_n,
    input wire logic dqOe_n,
    input wire logic [DQ_W-1:0] writeQuarterShift,
    input wire logic wrTake,
    input wire logic rdValid,
    input wire logic rdReady,
    input wire ddrx_beat_t rdBeat,
    input wire logic busy,
    input wire logic polarity
);
    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Write strobe lanes and its quarter-period lag
    a_lane_copy: assert property (
        writeQuarterShift == {DQ_W{strobeOut}}) else $error("lane copy");
    a_quarter_lag: assert property (
        wrTake |-> ##3 $changed(strobeOut)) else $error("strobe lag");
    a_write_drive: assert property (
        writeStart && !busy |-> ##2 (!strobeOe_n && !dqOe_n))
        else $error("write pins");
    // Read start and polarity hold
    a_read_start: assert property (
        readStart && !writeStart && !busy |=> busy) else $error("no read");
    a_pol_steady: assert property (
        $changed(polarity) |-> busy) else $error("polarity moved");
    a_beat_held: assert property (
        rdValid && !rdReady |=> rdValid && $stable(rdBeat))
        else $error("beat dropped");
    // Main scenarios reached
    c_write: cover property (wrTake);
    c_pol_high: cover property (busy && polarity);
    c_read_end: cover property ($fell(busy) && rdValid);
endmodule

bind ddrx_read_xfer ddrx_read_xfer_monitor i_ddrx_read_xfer_monitor(
    .ref_clk, .rst_n, .readStart, .writeStart, .strobeOut, .strobeOe_n,
    .dqOe_n, .writeQuarterShift, .wrTake, .rdValid, .rdReady, .rdBeat,
    .busy, .polarity);

// [bench/ddrx_mem_model.sv]
// Memory side model: drives read strobe and data, else floats high.
// Assumes ns units; the strobe half period is chosen per burst.
`timescale 1ns/1ps
module ddrx_mem_model import ddrx_pkg::*; (
    input wire logic strobeOut,
    input wire logic strobeOe_n,
    output logic strobeIn,
    output logic [DQ_W-1:0] dqIn
);
    logic drv = 1'b0;
    logic stb = 1'b1;
    // Pin level: device, memory, else termination pull-up
    assign strobeIn = !strobeOe_n ? strobeOut : (drv ? stb : 1'b1);
    initial dqIn = '0;
    // Preamble low, then one beat centred on each strobe edge
    task automatic burst(input logic [31:0] d, input int h);
        drv = 1'b1;
        stb = 1'b0;
        #(2 * h);
        for (int i = 0; i < 4; i++) begin
            dqIn = d[i*DQ_W +: DQ_W];
            #(h / 2);
            stb = ~stb;
            #(h / 2);
        end
        #(h);
        drv = 1'b0;
        dqIn = ~dqIn;
    endtask
endmodule

// [bench/ddrx_read_xfer_tb.sv]
// Bench for the strobe transfer block against a memory model.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ps
module ddrx_read_xfer_tb import ddrx_pkg::*;;
    logic ref_clk, rst_n, readStart, writeStart, rdReady, p0, tick;
    logic strobeIn, strobeOut, strobeOe_n, dqOe_n, wrTake;
    logic rdValid, busy, polarity, overrun;
    logic [DQ_W-1:0] dqIn, dqOut, writeQuarterShift, wrData;
    ddrx_beat_t rdBeat;
    int error_cnt, compares;
    ddrx_read_xfer i_ddrx_read_xfer(.ref_clk, .rst_n, .readStart,
        .writeStart, .strobeIn, .strobeOut, .strobeOe_n, .dqIn, .dqOut,
        .dqOe_n, .writeQuarterShift, .wrData, .wrTake, .rdValid, .rdReady,
        .rdBeat, .busy, .polarity, .overrun);
    ddrx_mem_model i_ddrx_mem_model(.strobeOut, .strobeOe_n, .strobeIn,
        .dqIn);
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Ref cycle parity, so every read starts on the same phase
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) tick <= 1'b0;
        else tick <= !tick;
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One read, memory burst after a phase offset
    task automatic rd(input logic [31:0] d, input int h, input int ph);
        @(posedge ref_clk);
        while (tick) @(posedge ref_clk);
        readStart <= 1'b1;
        @(posedge ref_clk);
        readStart <= 1'b0;
        #(ph);
        i_ddrx_mem_model.burst(d, h);
        repeat (8) @(posedge ref_clk);
        check(busy, 0);
    endtask
    // Take n beats with the consumer ready
    task automatic drain(input logic [31:0] d, input int n);
        int w;
        @(posedge ref_clk);
        rdReady <= 1'b1;
        for (int i = 0; i < n; i++) begin
            w = 0;
            do begin
                @(negedge ref_clk);
                w++;
            end while (rdValid !== 1'b1 && w < 200);
            check(rdBeat, {d[(i%4)*DQ_W +: DQ_W], i%4 == 3});
            @(posedge ref_clk);
        end
        rdReady <= 1'b0;
    endtask
    // Fill buffer to refusal; one more read overruns
    task automatic t_fill();
        for (int k = 0; k < 4; k++) rd(32'h1E2D_3C4B, 100, 5);
        check(overrun, 0);
        rd(32'h1E2D_3C4B, 100, 5);
        check(overrun, 1);
        drain(32'h1E2D_3C4B, FIFO_DEPTH);
        @(posedge ref_clk);
        rdReady <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rdReady <= 1'b0;
    endtask
    // One ref cycle later phase flips polarity; slow strobe too
    task automatic t_read();
        rd(32'hC3A5_5AF0, 100, 5);
        check(overrun, 0);
        drain(32'hC3A5_5AF0, 4);
        p0 = polarity;
        rd(32'h0F1E_2D3C, 100, 30);
        check(polarity, !p0);
        drain(32'h0F1E_2D3C, 4);
        rd(32'h9687_7869, 200, 5);
        drain(32'h9687_7869, 4);
    endtask
    // Write: four bytes, two strobe periods, pins released
    task automatic t_write();
        int takes, rises;
        logic t, last;
        logic [DQ_W-1:0] exp;
        takes = 0;
        rises = 0;
        t = 0;
        last = 0;
        @(posedge ref_clk);
        writeStart <= 1'b1;
        @(posedge ref_clk);
        writeStart <= 1'b0;
        repeat (30) begin
            @(negedge ref_clk);
            if (t) check(dqOut, exp);
            t = wrTake;
            if (t) begin
                takes++;
                exp = wrData;
            end
            rises += (strobeOut && !last);
            last = strobeOut;
            @(posedge ref_clk);
            if (t) wrData <= wrData + 8'h11;
        end
        check(takes, 4);
        check(rises, 2);
        check({busy, strobeOe_n, dqOe_n}, 3'h3);
    endtask
    // Reset, then scenarios
    initial begin
        rst_n = 1'b0;
        readStart = 1'b0;
        writeStart = 1'b0;
        rdReady = 1'b0;
        wrData = 8'h5A;
        error_cnt = 0;
        compares = 0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_fill();
        t_read();
        t_write();
        report_and_stop();
    end
    // Watchdog
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule
